// ===== pkg/sense_pkg.sv
// Purpose: Shared constants and types for the sense data error encoder.
// Assumes: Fixed-format sense data, byte-wide fields.
// Notes: Codes are the sense key, additional code and qualifier values.
`default_nettype none
package sense_pkg;

	// ****************************************************************
	// Sense keys and codes.
	// ****************************************************************
	localparam logic [3:0] key_none = 4'h0;
	localparam logic [3:0] key_illegal = 4'h5;
	localparam logic [3:0] key_aborted = 4'hB;
	localparam logic [3:0] key_miscompare = 4'hE;
	localparam logic [7:0] asc_none = 8'h00;
	localparam logic [7:0] asc_echo = 8'h3F;
	localparam logic [7:0] asc_internal = 8'h44;
	localparam logic [7:0] asc_crc = 8'h47;
	localparam logic [7:0] asc_phase = 8'h4B;
	localparam logic [7:0] asc_overlap = 8'h4E;
	localparam logic [7:0] asc_oob = 8'h4F;
	localparam logic [7:0] asc_zone = 8'h55;
	localparam logic [7:0] asc_verify = 8'h1D;
	localparam logic [7:0] q_00 = 8'h00;
	localparam logic [7:0] q_01 = 8'h01;
	localparam logic [7:0] q_02 = 8'h02;
	localparam logic [7:0] q_03 = 8'h03;
	localparam logic [7:0] q_04 = 8'h04;
	localparam logic [7:0] q_05 = 8'h05;
	localparam logic [7:0] q_06 = 8'h06;
	localparam logic [7:0] q_0e = 8'h0E;
	localparam logic [7:0] q_0f = 8'h0F;
	localparam logic [7:0] unit_code_default = 8'h00;

	// ****************************************************************
	// Byte 15 field positions in the illegal request layout.
	// ****************************************************************
	localparam int valid_bit = 7;
	localparam int cd_bit = 6;
	localparam int pointer_valid_bit = 3;
	localparam int num_causes = 14;

	// Error causes, one bit each on the request vector, lowest index wins.
	typedef enum logic [3:0] {
		cause_echo = 4'h0,
		cause_bufcrc = 4'h1,
		cause_dram = 4'h2,
		cause_credit = 4'h3,
		cause_length = 4'h4,
		cause_timeout = 4'h5,
		cause_nobuf = 4'h6,
		cause_crc = 4'h7,
		cause_phase = 4'h8,
		cause_toomuch = 4'h9,
		cause_acknak = 4'hA,
		cause_nak = 4'hB,
		cause_offset = 4'hC,
		cause_init = 4'hD
	} cause_e;

endpackage : sense_pkg
`default_nettype wire

// ===== pkg/sense_if.sv
// Purpose: Carries a chosen cause code between the encoder and its lookup.
// Assumes: One clock domain.
// Notes: The lookup answers one cycle after the code is presented.
`default_nettype none
interface sense_if;
	logic [3:0] cause;
	logic [3:0] key;
	logic [7:0] asc;
	logic [7:0] ascq;
	modport requester (output cause, input key, asc, ascq);
	modport table_side (input cause, output key, asc, ascq);
endinterface : sense_if
`default_nettype wire

// ===== verilog/sense_code_table.sv
// Purpose: Registered lookup from an aborted-command cause to its codes.
// Assumes: Cause encoding from the shared package.
// Notes: Read data come out of a register one cycle after the cause.
`default_nettype none
module sense_code_table (
	input wire logic clock,
	input wire logic rst,
	sense_if.table_side port
);
	logic [3:0] key_next;
	logic [7:0] asc_next;
	logic [7:0] ascq_next;
	logic [3:0] key_reg;
	logic [7:0] asc_reg;
	logic [7:0] ascq_reg;

	// Every listed cause is an aborted command; only the codes differ.
	always_comb
	begin
		key_next = sense_pkg::key_aborted;
		asc_next = sense_pkg::asc_internal;
		ascq_next = sense_pkg::q_00;
		unique case (port.cause)
			sense_pkg::cause_echo:
			begin
				asc_next = sense_pkg::asc_echo; // (R1)
				ascq_next = sense_pkg::q_0f; // (R1)
			end
			sense_pkg::cause_bufcrc, sense_pkg::cause_dram, sense_pkg::cause_credit,
			sense_pkg::cause_length, sense_pkg::cause_timeout, sense_pkg::cause_nobuf:
			begin
				asc_next = sense_pkg::asc_internal; // (R2)
				ascq_next = sense_pkg::q_00; // (R2)
			end
			sense_pkg::cause_crc:
			begin
				asc_next = sense_pkg::asc_crc; // (R3)
				ascq_next = sense_pkg::q_01; // (R3)
			end
			sense_pkg::cause_phase:
			begin
				asc_next = sense_pkg::asc_phase; // (R4)
				ascq_next = sense_pkg::q_00; // (R4)
			end
			sense_pkg::cause_toomuch:
			begin
				asc_next = sense_pkg::asc_phase; // (R5)
				ascq_next = sense_pkg::q_02; // (R5)
			end
			sense_pkg::cause_acknak:
			begin
				asc_next = sense_pkg::asc_phase; // (R6)
				ascq_next = sense_pkg::q_03; // (R6)
			end
			sense_pkg::cause_nak:
			begin
				asc_next = sense_pkg::asc_phase; // (R7)
				ascq_next = sense_pkg::q_04; // (R7)
			end
			sense_pkg::cause_offset:
			begin
				asc_next = sense_pkg::asc_phase; // (R8)
				ascq_next = sense_pkg::q_05; // (R8)
			end
			sense_pkg::cause_init:
			begin
				asc_next = sense_pkg::asc_phase; // (R9)
				ascq_next = sense_pkg::q_06; // (R9)
			end
			default:
			begin
				// Unused codes fall back to an internal failure report.
				asc_next = sense_pkg::asc_internal;
				ascq_next = sense_pkg::q_00;
			end
		endcase
	end

	// Register the lookup so downstream timing stays short.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			key_reg <= 4'h0;
			asc_reg <= 8'h00;
			ascq_reg <= 8'h00;
		end
		else
		begin
			key_reg <= key_next;
			asc_reg <= asc_next;
			ascq_reg <= ascq_next;
		end
	end

	assign port.key = key_reg;
	assign port.asc = asc_reg;
	assign port.ascq = ascq_reg;
endmodule : sense_code_table
`default_nettype wire

// ===== verilog/sense_data_error_encoder.sv
// Purpose: Encodes a reported error into fixed-format sense fields.
// Assumes: Requests are single-cycle pulses synchronous to clock.
// Notes: Answer appears three cycles after a request, marked by sense_ready.
// What this block does
// (R1) Echo buffer overwritten reports key B, code 3F, qualifier 0F.
// (R2) Internal failures report key B, code 44, qualifier 00.
// (R3) Data phase CRC error reports key B, code 47, qualifier 01.
// (R4) General data phase error reports key B, code 4B, qualifier 00.
// (R5) Too much write data reports key B, code 4B, qualifier 02.
// (R6) ACK/NAK timeout or link break reports key B, code 4B, qualifier 03.
// (R7) Negative acknowledge received reports key B, code 4B, qualifier 04.
// (R8) Bad data offset reports key B, code 4B, qualifier 05.
// (R9) Initiator response timeout reports key B, code 4B, qualifier 06.
// (R10) Overlapped commands report key B, code 4E, qualifier 00.
// (R11) Out-of-band abort reports key B, code 4F, qualifier 00.
// (R12) Insufficient zone resources report key B, code 55, qualifier 0E.
// (R13) Verify miscompare reports key E, code 1D, qualifier 00.
// (R14) Replaceable unit byte is zero unless a vendor value is configured.
// (R15) Bytes 15 to 17 layout follows the reported sense key.
// (R16) Illegal requests, key 5, return a field pointer.
// (R17) Byte 15: valid bit 7, C/D bit 6, pointer-valid bit 3, pointer 2..0.
// (R18) Valid flag is one only when the specific bytes mean something.
// (R19) C/D is one for the command block, zero for parameter data.
// (R20) Bit pointer valid is one only when the bit pointer matters.
// (R21) Bit pointer names the most significant erroneous bit.
// (R22) Field pointer gives the most significant erroneous byte index.
// (R23) Bits 5 and 4 of byte 15 read as zero.
`default_nettype none
module sense_data_error_encoder #(
	parameter int field_width = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [13:0] abort_cause,
	input wire logic overlap_error,
	input wire logic oob_abort,
	input wire logic zone_shortage,
	input wire logic verify_miscompare,
	input wire logic illegal_request,
	input wire logic illegal_in_cdb,
	input wire logic bit_pointer_known,
	input wire logic [2:0] bit_pointer,
	input wire logic [field_width-1:0] field_pointer,
	input wire logic vendor_unit_enable,
	input wire logic [7:0] vendor_unit_code,
	output logic sense_ready,
	output logic [3:0] sense_key,
	output logic [7:0] sense_code,
	output logic [7:0] sense_qualifier,
	output logic [7:0] replaceable_unit_code,
	output logic [7:0] specific_byte15,
	output logic [7:0] specific_byte16,
	output logic [7:0] specific_byte17
);

	// ****************************************************************
	// Request capture.
	// ****************************************************************

	// Two-step pipeline: capture, then table answer; Gray along the path.
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_lookup = 2'b01,
		st_emit = 2'b11
	} stage_e;

	typedef enum logic [2:0] {
		src_table = 3'h0,
		src_overlap = 3'h1,
		src_oob = 3'h2,
		src_zone = 3'h3,
		src_verify = 3'h4,
		src_illegal = 3'h5
	} source_e;

	sense_if lookup ();

	stage_e stage_reg, stage_next;
	source_e src_reg, src_next;
	logic [3:0] cause_reg, cause_next;
	logic cd_reg, cd_next;
	logic ptr_valid_reg, ptr_valid_next;
	logic [2:0] bitptr_reg, bitptr_next;
	logic [field_width-1:0] field_reg, field_next;
	logic any_request;
	logic [3:0] first_cause;

	sense_code_table table_inst (
		.clock(clock),
		.rst(rst),
		.port(lookup.table_side)
	);

	assign lookup.cause = cause_reg;

	// Lowest numbered abort cause wins when several arrive together.
	always_comb
	begin
		first_cause = 4'h0;
		for (int i = sense_pkg::num_causes - 1; i >= 0; i--)
		begin
			if (abort_cause[i])
			begin
				first_cause = 4'(i);
			end
		end
	end

	assign any_request = (|abort_cause) | overlap_error | oob_abort | zone_shortage
		| verify_miscompare | illegal_request;

	// New requests are taken only in idle; a busy encoder ignores them.
	always_comb
	begin
		stage_next = stage_reg;
		src_next = src_reg;
		cause_next = cause_reg;
		cd_next = cd_reg;
		ptr_valid_next = ptr_valid_reg;
		bitptr_next = bitptr_reg;
		field_next = field_reg;
		unique case (stage_reg)
			st_idle:
			begin
				if (any_request)
				begin
					stage_next = st_lookup;
					cause_next = first_cause;
					cd_next = illegal_in_cdb; // (R19)
					ptr_valid_next = bit_pointer_known; // (R20)
					bitptr_next = bit_pointer_known ? bit_pointer : 3'h0; // (R21)
					field_next = field_pointer; // (R22)
					if (illegal_request)
						src_next = src_illegal;
					else if (|abort_cause)
						src_next = src_table;
					else if (overlap_error)
						src_next = src_overlap;
					else if (oob_abort)
						src_next = src_oob;
					else if (zone_shortage)
						src_next = src_zone;
					else
						src_next = src_verify;
				end
			end
			st_lookup:
			begin
				stage_next = st_emit;
			end
			st_emit:
			begin
				stage_next = st_idle;
			end
			default:
			begin
				stage_next = st_idle;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			stage_reg <= st_idle;
			src_reg <= src_table;
			cause_reg <= 4'h0;
			cd_reg <= 1'b0;
			ptr_valid_reg <= 1'b0;
			bitptr_reg <= 3'h0;
			field_reg <= '0;
		end
		else
		begin
			stage_reg <= stage_next;
			src_reg <= src_next;
			cause_reg <= cause_next;
			cd_reg <= cd_next;
			ptr_valid_reg <= ptr_valid_next;
			bitptr_reg <= bitptr_next;
			field_reg <= field_next;
		end
	end

	// ****************************************************************
	// Sense field assembly.
	// ****************************************************************

	logic ready_next;
	logic [3:0] key_next;
	logic [7:0] code_next;
	logic [7:0] qual_next;
	logic [7:0] unit_next;
	logic [7:0] b15_next;
	logic [7:0] b16_next;
	logic [7:0] b17_next;
	logic [15:0] field_wide;

	// The field pointer is always presented as two big-endian bytes.
	assign field_wide = 16'(field_reg);

	// Outputs other than sense_ready hold the last answer until the next one replaces it.
	always_comb
	begin
		ready_next = 1'b0;
		key_next = sense_key;
		code_next = sense_code;
		qual_next = sense_qualifier;
		unit_next = replaceable_unit_code;
		b15_next = specific_byte15;
		b16_next = specific_byte16;
		b17_next = specific_byte17;
		if (stage_reg == st_emit)
		begin
			ready_next = 1'b1;
			// Vendor builds may park their own value in this byte.
			unit_next = vendor_unit_enable ? vendor_unit_code : sense_pkg::unit_code_default; // (R14)
			// Other keys get no specific bytes, so the valid flag stays low.
			b15_next = 8'h00; // (R15) (R18)
			b16_next = 8'h00;
			b17_next = 8'h00;
			unique case (src_reg)
				src_table:
				begin
					key_next = lookup.key;
					code_next = lookup.asc;
					qual_next = lookup.ascq;
				end
				src_overlap:
				begin
					key_next = sense_pkg::key_aborted; // (R10)
					code_next = sense_pkg::asc_overlap; // (R10)
					qual_next = sense_pkg::q_00; // (R10)
				end
				src_oob:
				begin
					key_next = sense_pkg::key_aborted; // (R11)
					code_next = sense_pkg::asc_oob; // (R11)
					qual_next = sense_pkg::q_00; // (R11)
				end
				src_zone:
				begin
					key_next = sense_pkg::key_aborted; // (R12)
					code_next = sense_pkg::asc_zone; // (R12)
					qual_next = sense_pkg::q_0e; // (R12)
				end
				src_verify:
				begin
					key_next = sense_pkg::key_miscompare; // (R13)
					code_next = sense_pkg::asc_verify; // (R13)
					qual_next = sense_pkg::q_00; // (R13)
				end
				src_illegal:
				begin
					// Codes for illegal requests come from elsewhere; zero here.
					key_next = sense_pkg::key_illegal; // (R16)
					code_next = sense_pkg::asc_none;
					qual_next = sense_pkg::q_00;
					b15_next[sense_pkg::valid_bit] = 1'b1; // (R17) (R18)
					b15_next[sense_pkg::cd_bit] = cd_reg; // (R17) (R19)
					b15_next[sense_pkg::pointer_valid_bit] = ptr_valid_reg; // (R17) (R20)
					b15_next[2:0] = bitptr_reg; // (R17) (R21) (R23)
					b16_next = field_wide[15:8]; // (R17) (R22)
					b17_next = field_wide[7:0]; // (R17) (R22)
				end
				default:
				begin
					key_next = sense_pkg::key_none;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sense_ready <= 1'b0;
			sense_key <= 4'h0;
			sense_code <= 8'h00;
			sense_qualifier <= 8'h00;
			replaceable_unit_code <= 8'h00;
			specific_byte15 <= 8'h00;
			specific_byte16 <= 8'h00;
			specific_byte17 <= 8'h00;
		end
		else
		begin
			sense_ready <= ready_next;
			sense_key <= key_next;
			sense_code <= code_next;
			sense_qualifier <= qual_next;
			replaceable_unit_code <= unit_next;
			specific_byte15 <= b15_next;
			specific_byte16 <= b16_next;
			specific_byte17 <= b17_next;
		end
	end

endmodule : sense_data_error_encoder
`default_nettype wire

// ===== bench/sense_encoder_checker.sv
// Purpose: Port-level assertions for the sense data error encoder.
// Assumes: An answer is sampled three edges after its request is taken.
// Notes: Bound to every encoder instance at the foot of this file.
`default_nettype none
module sense_encoder_checker #(
	parameter int field_width = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [13:0] abort_cause,
	input wire logic overlap_error,
	input wire logic oob_abort,
	input wire logic zone_shortage,
	input wire logic verify_miscompare,
	input wire logic illegal_request,
	input wire logic illegal_in_cdb,
	input wire logic bit_pointer_known,
	input wire logic [2:0] bit_pointer,
	input wire logic [field_width-1:0] field_pointer,
	input wire logic vendor_unit_enable,
	input wire logic [7:0] vendor_unit_code,
	input wire logic sense_ready,
	input wire logic [3:0] sense_key,
	input wire logic [7:0] sense_code,
	input wire logic [7:0] sense_qualifier,
	input wire logic [7:0] replaceable_unit_code,
	input wire logic [7:0] specific_byte15,
	input wire logic [7:0] specific_byte16,
	input wire logic [7:0] specific_byte17
);
	// ****************************************************************
	// Acceptance tracking.
	// ****************************************************************
	logic [1:0] wait_reg;
	logic [1:0] wait_next;
	logic req;
	logic take;

	// A taken request makes the encoder deaf for the next two edges.
	always_comb
	begin
		req = (|abort_cause) | overlap_error | oob_abort | zone_shortage | verify_miscompare | illegal_request;
		take = req && (wait_reg == 2'h0);
		wait_next = take ? 2'h2 : ((wait_reg == 2'h0) ? 2'h0 : wait_reg - 2'h1);
	end

	// Register the deaf window.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			wait_reg <= 2'h0;
		else
			wait_reg <= wait_next;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// ****************************************************************
	// Assertions and covers.
	// ****************************************************************
	AST_LATENCY: assert property (take |-> ##3 sense_ready)
		else $error("answer missing three edges after a request");
	AST_NO_SPURIOUS: assert property (sense_ready |-> $past(take, 3))
		else $error("answer without a taken request");
	AST_ECHO: assert property (take && !illegal_request && abort_cause[0]
		|-> ##3 {sense_key, sense_code, sense_qualifier} == 20'hB3F0F) else $error("echo codes wrong");
	AST_INTERNAL: assert property (take && !illegal_request && !abort_cause[0] && (|abort_cause[6:1])
		|-> ##3 {sense_key, sense_code, sense_qualifier} == 20'hB4400) else $error("internal codes wrong");
	AST_VERIFY: assert property (take && verify_miscompare && !illegal_request && abort_cause == 14'h0
		&& !overlap_error && !oob_abort && !zone_shortage
		|-> ##3 {sense_key, sense_code, sense_qualifier} == 20'hE1D00) else $error("miscompare codes wrong");
	AST_BYTE15: assert property (take && illegal_request |-> ##3 sense_key == 4'h5 &&
		specific_byte15 == {1'b1, $past(illegal_in_cdb, 3), 2'h0, $past(bit_pointer_known, 3),
		$past(bit_pointer, 3) & {3{$past(bit_pointer_known, 3)}}}) else $error("byte 15 wrong");
	AST_FIELD: assert property (take && illegal_request
		|-> ##3 {specific_byte16, specific_byte17} == 16'($past(field_pointer, 3))) else $error("field pointer wrong");
	AST_OTHER_ZERO: assert property (sense_ready && sense_key != 4'h5
		|-> {specific_byte15, specific_byte16, specific_byte17} == 24'h0) else $error("specific bytes not zero");
	AST_UNIT_ZERO: assert property (sense_ready && !$past(vendor_unit_enable) && !$past(vendor_unit_enable, 2)
		|-> replaceable_unit_code == 8'h00) else $error("unit byte not zero");
	cover property (take && illegal_request);
	cover property (sense_ready && sense_key == 4'hB);
	cover property (take && $past(take, 3));
endmodule : sense_encoder_checker

bind sense_data_error_encoder sense_encoder_checker #(.field_width(field_width)) u_checker (.*);
`default_nettype wire

// ===== bench/sense_host_model.sv
// Purpose: Initiator side that counts each answered sense record.
// Assumes: One answer per sense_ready pulse.
// Notes: Only counts answers; contents are judged by the bench.
`default_nettype none
module sense_host_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic sense_ready,
	output logic [7:0] answers
);
	// ****************************************************************
	// Answer counter.
	// ****************************************************************
	// Counting at the edge shows an extra pulse that a level check would miss.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			answers <= 8'h00;
		else if (sense_ready)
			answers <= answers + 8'h01;
	end
endmodule : sense_host_model
`default_nettype wire

// ===== bench/test_sense_data_error_encoder.sv
// Purpose: Self-checking bench for the sense data error encoder.
// Assumes: Requests are taken three edges apart at most once.
// Notes: Table rows first, then unit code, overlap and reset cases.
`default_nettype none
module test_sense_data_error_encoder;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [18:0] req; logic [20:0] ill; logic [55:0] exp;} row_s;
	logic clock;
	logic rst;
	logic [18:0] req;
	logic [20:0] ill;
	logic ven_en;
	logic [7:0] ven_code;
	logic sense_ready;
	logic [3:0] sense_key;
	logic [7:0] sense_code;
	logic [7:0] sense_qualifier;
	logic [7:0] replaceable_unit_code;
	logic [7:0] specific_byte15;
	logic [7:0] specific_byte16;
	logic [7:0] specific_byte17;
	logic [7:0] answers;
	logic [7:0] c;
	logic [7:0] q;
	int err_total;
	int n_compared;
	int i;
	int k;
	row_s rows [24];

	sense_data_error_encoder #(.field_width(16)) u_dut (.clock(clock), .rst(rst), .abort_cause(req[13:0]),
		.overlap_error(req[14]), .oob_abort(req[15]), .zone_shortage(req[16]), .verify_miscompare(req[17]),
		.illegal_request(req[18]), .illegal_in_cdb(ill[20]), .bit_pointer_known(ill[19]),
		.bit_pointer(ill[18:16]), .field_pointer(ill[15:0]), .vendor_unit_enable(ven_en),
		.vendor_unit_code(ven_code), .sense_ready(sense_ready), .sense_key(sense_key), .sense_code(sense_code),
		.sense_qualifier(sense_qualifier), .replaceable_unit_code(replaceable_unit_code),
		.specific_byte15(specific_byte15), .specific_byte16(specific_byte16), .specific_byte17(specific_byte17));
	sense_host_model u_host (.clock(clock), .rst(rst), .sense_ready(sense_ready), .answers(answers));

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	// Free-running 125 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [63:0] outs();
		return {7'h0, sense_ready, 4'h0, sense_key, sense_code, sense_qualifier, replaceable_unit_code,
			specific_byte15, specific_byte16, specific_byte17};
	endfunction : outs

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// Waits on falling edges, so the answer is read well clear of the launch edge.
	task automatic wait_ready(output int n);
		for (n = 1; n <= 8; n++)
		begin
			@(negedge clock);
			if (sense_ready === 1'b1)
				return;
		end
		err_total++;
		results();
	endtask : wait_ready

	// One request held for exactly one cycle, then the answer is checked.
	task automatic op(input logic [18:0] r, input logic [20:0] f, input logic [55:0] exp);
		int n;
		@(posedge clock);
		req <= r;
		ill <= f;
		@(posedge clock);
		req <= 19'h0;
		wait_ready(n);
		check(64'(n), 64'h3);
		check(outs(), {8'h01, exp});
	endtask : op

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial
	begin
		rst = 1'b1;
		req = 19'h0;
		ill = 21'h0;
		ven_en = 1'b0;
		ven_code = 8'h00;
		err_total = 0;
		n_compared = 0;
		for (i = 0; i < 14; i++)
		begin
			c = (i == 0) ? 8'h3F : (i < 7) ? 8'h44 : (i == 7) ? 8'h47 : 8'h4B;
			q = (i == 0) ? 8'h0F : (i == 7) ? 8'h01 : (i > 8) ? 8'(i - 7) : 8'h00;
			rows[i] = '{19'h1 << i, 21'h0, {8'h0B, c, q, 32'h0}};
		end
		rows[14] = '{19'h04000, 21'h0, 56'h0B4E0000000000};
		rows[15] = '{19'h08000, 21'h0, 56'h0B4F0000000000};
		rows[16] = '{19'h10000, 21'h0, 56'h0B550E00000000};
		rows[17] = '{19'h20000, 21'h0, 56'h0E1D0000000000};
		rows[18] = '{19'h40000, 21'h1FABCD, 56'h05000000CFABCD};
		rows[19] = '{19'h40000, 21'h050001, 56'h05000000800001};
		rows[20] = '{19'h7FFFF, 21'h0A0102, 56'h050000008A0102};
		rows[21] = '{19'h3C006, 21'h0, 56'h0B440000000000};
		rows[22] = '{19'h3C000, 21'h0, 56'h0B4E0000000000};
		rows[23] = '{19'h30000, 21'h0, 56'h0B550E00000000};
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		check(outs(), 64'h0);
		for (i = 0; i < 24; i++)
			op(rows[i].req, rows[i].ill, rows[i].exp);
		$display("Table rows done");
		// A configured vendor value replaces the zero unit byte.
		@(posedge clock);
		ven_en <= 1'b1;
		ven_code <= 8'h5A;
		op(19'h08000, 21'h0, 56'h0B4F005A000000);
		@(posedge clock);
		ven_en <= 1'b0;
		$display("Unit code case done");
		// A second request held through the deaf window is taken only at the third edge.
		// Read the count clear of the edge at which the host counts the last answer.
		@(negedge clock);
		i = answers;
		@(posedge clock);
		req <= 19'h00001;
		@(posedge clock);
		req <= 19'h20000;
		repeat (3) @(posedge clock);
		req <= 19'h0;
		wait_ready(k);
		check(64'(k), 64'h3);
		check(outs(), 64'h010E1D0000000000);
		@(negedge clock);
		check(64'(answers - 8'(i)), 64'h2);
		$display("Back-to-back case done");
		// Reset in mid-operation drops the pending answer.
		@(posedge clock);
		req <= 19'h40000;
		ill <= 21'h1FABCD;
		@(posedge clock);
		req <= 19'h0;
		rst <= 1'b1;
		@(negedge clock);
		check(outs(), 64'h0);
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(negedge clock);
		check(outs(), 64'h0);
		$display("Mid-run reset case done");
		results();
	end
endmodule : test_sense_data_error_encoder
`default_nettype wire
